// File: rtl/sram_pkg.sv
/*
  Shared constants and bus types for the pipelined burst memory block.
  Assumes a single 100 MHz system clock and four byte lanes of nine bits.
*/
package sram_pkg;

  // ==========================================================
  // Geometry
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int ADDR_W_DEF = 19;
  localparam int BURST_W = 2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_TIME_CYC = 2;
  localparam int SLEEP_SYNC_STAGES = SLEEP_TIME_CYC;

  // ==========================================================
  // Reset values
  localparam logic LINEAR_RST = 1'b0;
  localparam logic [BURST_W-1:0] BEAT_RST = 2'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  // ==========================================================
  // Synchronous control pins, sampled together on the clock
  typedef struct packed {
    logic chip_select_primary_n;
    logic chip_select_high;
    logic chip_select_low_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [LANES-1:0] byte_lane_write_n;
  } bus_ctl_t;

endpackage

// File: rtl/burst_seq.sv
/*
  Two-bit burst address generator for linear or interleaved order.
  Assumes start and beat are stable within the cycle; purely combinational.
*/
`timescale 1ns/100ps
module burst_seq (
  // Burst position
  input wire logic [1:0] start,
  input wire logic [1:0] beat,
  // Order select
  input wire logic linear,
  // Generated low address bits
  output logic [1:0] addr
);

  // ==========================================================
  // Sequence
  always_comb begin
    if (linear) begin
      addr = 2'(start + beat);
    end else begin
      addr = start ^ beat;
    end
  end

endmodule

// File: rtl/sram_burst_core.sv
/*
  Pipelined burst static memory core with two address strobes and sleep.
  Assumes all control, address and data inputs are synchronous to CLK_SYS;
  the output enable and sleep request are asynchronous.
*/
// What this block does
// - Ground strap selects linear, else interleaved order
// - Inputs and read data registered on clock
// - Two-bit wraparound counter loads low address
// - Global write writes every lane
// - Selected strobe with no writes starts read
// - Read data drives after next edge
// - First cycle after deselect stays tri-stated
// - Deselect tri-states data at once
// - Processor strobe cycle ignores writes, advance
// - Processor strobe write completes second clock
// - Byte write touches only selected lanes
// - Write cycle turns data drivers off
// - Controller strobe write completes in one cycle
// - Controller strobe load ignores burst advance
// - Advance low steps the burst counter
// - Sleep is asynchronous, two cycles, keeps data
// - Access pending at sleep is dropped
// - Interleaved order XORs start with beat
// - Linear order adds beat modulo four
// - Processor strobe with all chip selects active begins a read
// - Write when global or selected byte write
`timescale 1ns/100ps
module sram_burst_core #(
  parameter int ADDR_W = sram_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Synchronous bus
  input wire sram_pkg::bus_ctl_t CTL,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [sram_pkg::DATA_W-1:0] D_I,
  // Asynchronous controls and strap
  input wire logic OUT_ENABLE_N,
  input wire logic SLEEP_REQUEST,
  input wire logic BURST_ORDER_STRAP,
  // Data out and its enable, low while driving
  output logic [sram_pkg::DATA_W-1:0] D_O,
  output logic D_OE_N
);
  import sram_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ==========================================================
  // Decode of the sampled pins
  logic cs_ok, processor_address_strobe_n_go, controller_address_strobe_n_go, strobe, is_wr;
  logic load, desel_now, cont, step, wr_now, rd_now;
  logic [LANES-1:0] lane_we;
  logic [1:0] seq_low;
  logic [ADDR_W-1:0] cur_addr;

  logic active_q, active_d;
  logic [1:0] base_q, base_d;
  logic [1:0] beat_q, beat_d;
  logic [ADDR_W-3:0] hi_q, hi_d;
  logic rd_v_q, rd_v_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic drive_q, drive_d;
  logic linear_q, linear_d;
  logic strap_seen_q, strap_seen_d;
  logic sleep_meta_q, sleep_q;
  logic [DATA_W-1:0] mem_q [DEPTH];

  always_comb begin
    cs_ok = !CTL.chip_select_primary_n && CTL.chip_select_high
      && !CTL.chip_select_low_n;
    // Processor strobe needs the primary select and beats the other
    processor_address_strobe_n_go = !CTL.processor_address_strobe_n
      && !CTL.chip_select_primary_n;
    controller_address_strobe_n_go = !processor_address_strobe_n_go && !CTL.controller_address_strobe_n;
    strobe = processor_address_strobe_n_go || controller_address_strobe_n_go;
    is_wr = !CTL.global_write_n || (!CTL.byte_write_enable_n
      && (CTL.byte_lane_write_n != LANES_ALL));
    load = strobe && !sleep_q;
    desel_now = load && !cs_ok;
    cont = !strobe && active_q && !sleep_q;
    // Advance is only looked at outside a load cycle
    step = cont && !CTL.burst_step_n;
    // Processor strobe load never writes; its write is the next clock
    wr_now = (controller_address_strobe_n_go && load && cs_ok && is_wr)
      || (cont && is_wr);
    rd_now = (load && cs_ok && !(controller_address_strobe_n_go && is_wr))
      || (cont && !is_wr);
    if (!CTL.global_write_n) begin
      lane_we = LANES_ALL;
    end else if (!CTL.byte_write_enable_n) begin
      lane_we = ~CTL.byte_lane_write_n;
    end else begin
      lane_we = LANES_NONE;
    end
  end

  // ==========================================================
  // Burst counter
  burst_seq u_seq (
    .start(base_q),
    .beat(beat_d),
    .linear(linear_q),
    .addr(seq_low)
  );

  always_comb begin
    base_d = base_q;
    hi_d = hi_q;
    beat_d = beat_q;
    if (load && cs_ok) begin
      base_d = ADDR[1:0];
      hi_d = ADDR[ADDR_W-1:2];
      beat_d = BEAT_RST;
    end else if (step) begin
      beat_d = 2'(beat_q + 2'h1);
    end
    if (load) begin
      cur_addr = ADDR;
    end else begin
      cur_addr = {hi_q, seq_low};
    end
  end

  // ==========================================================
  // Access pipeline and output stage
  always_comb begin
    active_d = active_q;
    if (sleep_q || desel_now) begin
      active_d = 1'b0;
    end else if (load) begin
      active_d = 1'b1;
    end
    rd_v_d = rd_now && !sleep_q;
    rd_addr_d = cur_addr;
    rd_d = rd_q;
    if (rd_v_q) begin
      rd_d = mem_q[rd_addr_q];
    end
    // After a deselected cycle no read is in flight, so the first
    // cycle of a new access keeps the pins off
    drive_d = rd_v_q && !desel_now && !wr_now
      && !sleep_q;
    // Strap is caught once after reset; it must not move later
    linear_d = linear_q;
    strap_seen_d = 1'b1;
    if (!strap_seen_q) begin
      linear_d = !BURST_ORDER_STRAP;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      active_q <= 1'b0;
      base_q <= BEAT_RST;
      beat_q <= BEAT_RST;
      hi_q <= '0;
      rd_v_q <= 1'b0;
      rd_addr_q <= '0;
      rd_q <= '0;
      drive_q <= 1'b0;
      linear_q <= LINEAR_RST;
      strap_seen_q <= 1'b0;
    end else begin
      active_q <= active_d;
      base_q <= base_d;
      beat_q <= beat_d;
      hi_q <= hi_d;
      rd_v_q <= rd_v_d;
      rd_addr_q <= rd_addr_d;
      rd_q <= rd_d;
      drive_q <= drive_d;
      linear_q <= linear_d;
      strap_seen_q <= strap_seen_d;
    end
  end

  // ==========================================================
  // Array, written per lane; no reset so contents survive sleep
  always_ff @(posedge CLK_SYS) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_now && lane_we[i]) begin
        mem_q[cur_addr][i*LANE_W +: LANE_W] <=
          D_I[i*LANE_W +: LANE_W];
      end
    end
  end

  // ==========================================================
  // Sleep request synchroniser: two edges to enter or leave
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sleep_meta_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      sleep_meta_q <= SLEEP_REQUEST;
      sleep_q <= sleep_meta_q;
    end
  end

  // ==========================================================
  // Pins; enable is asynchronous to follow the output enable pin
  assign D_O = rd_q;
  assign D_OE_N = !(drive_q && !OUT_ENABLE_N);

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  a_processor_address_strobe_n_no_write: assert property (processor_address_strobe_n_go |-> !wr_now)
    else $error("write taken in processor strobe cycle");
  a_desel_tristate: assert property (desel_now |=> D_OE_N)
    else $error("pins driven after deselect");
  a_write_off: assert property (wr_now |=> !drive_q)
    else $error("drivers on after write cycle");
  a_read_latency: assert property (
    rd_now ##1 (!wr_now && !desel_now && !sleep_q)
    |=> drive_q && rd_q == $past(mem_q[rd_addr_q]))
    else $error("read data not out one cycle late");
  a_first_masked: assert property (
    !active_q && load && cs_ok |=> !drive_q)
    else $error("first cycle after deselect driven");
  a_global_write: assert property (
    wr_now && !CTL.global_write_n
    |=> mem_q[$past(cur_addr)] == $past(D_I))
    else $error("global write missed a lane");
  a_lane_keep: assert property (
    wr_now && CTL.global_write_n && CTL.byte_lane_write_n[0]
    |=> mem_q[$past(cur_addr)][LANE_W-1:0]
      == $past(mem_q[cur_addr][LANE_W-1:0]))
    else $error("unselected lane changed");
  a_burst_step: assert property (
    step |=> beat_q == 2'($past(beat_q) + 2'h1))
    else $error("burst counter did not step");
  a_controller_address_strobe_n_no_step: assert property (
    controller_address_strobe_n_go && load && cs_ok |=> beat_q == BEAT_RST)
    else $error("advance honoured in load cycle");
  a_sleep_enter: assert property (
    SLEEP_REQUEST [*2] |=> sleep_q)
    else $error("sleep not entered in two cycles");
  a_sleep_drop: assert property (
    sleep_q |=> !active_q && !drive_q && !rd_v_q)
    else $error("access survived sleep");

  c_read: cover property (rd_now ##2 !D_OE_N);
  c_processor_address_strobe_n_write: cover property (processor_address_strobe_n_go && cs_ok ##1 wr_now);
  c_controller_address_strobe_n_write: cover property (controller_address_strobe_n_go && cs_ok && is_wr);
  c_sleep: cover property (sleep_q ##1 !sleep_q);

endmodule

// File: tb/bus_model.sv
/*
  Behavioural bus controller driving the burst memory's synchronous pins.
  Assumes its tasks are entered 1 ns after a rising clock edge.
*/
`timescale 1ns/100ps
module bus_model (
  // Clock
  input wire logic clk,
  // Bus toward the memory
  output sram_pkg::bus_ctl_t ctl,
  output logic [5:0] addr,
  output logic [sram_pkg::DATA_W-1:0] d_i,
  output logic oe_n
);
  import sram_pkg::*;
  // ==========================================================
  // Cycle helpers
  function automatic bus_ctl_t mk(input logic cs, ap, ac, st, gw, be,
                                  input logic [3:0] bw);
    return '{cs, 1'b1, 1'b0, ap, ac, st, gw, be, bw};
  endfunction
  task automatic cyc(input bus_ctl_t c, input logic [5:0] a);
    ctl = c;
    addr = a;
    @(posedge clk);
    #1;
  endtask
  // Deselect cycles; released data lines toggle, never a stale value
  task automatic idle(input int n);
    repeat (n) begin
      d_i = ~d_i;
      cyc(mk(1, 1, 0, 1, 1, 1, 4'hF), ~addr);
    end
  endtask
  task automatic cwrite(input logic [5:0] a, input logic [DATA_W-1:0] d,
                        input logic gw, be, input logic [3:0] bw);
    oe_n = 1'b1;
    d_i = d;
    cyc(mk(0, 1, 0, 0, gw, be, bw), a);
  endtask
  // Write inputs asserted on the load cycle too: must be ignored
  task automatic pwrite(input logic [5:0] a, input logic [DATA_W-1:0] d);
    oe_n = 1'b1;
    cyc(mk(0, 0, 1, 0, 0, 0, 4'h0), a);
    d_i = d;
    cyc(mk(0, 1, 1, 1, 0, 1, 4'hF), ~a);
  endtask
  // Pad cycle lets the last beat show before the deselect
  task automatic read(input logic [5:0] a, input int n);
    oe_n = 1'b0;
    cyc(mk(0, 0, 1, 1, 1, 1, 4'hF), a);
    repeat (n - 1) cyc(mk(0, 1, 1, 0, 1, 1, 4'hF), ~addr);
    cyc(mk(0, 1, 1, 1, 1, 1, 4'hF), ~addr);
    idle(1);
  endtask
  initial begin
    ctl = mk(1, 1, 0, 1, 1, 1, 4'hF);
    addr = '0;
    d_i = '0;
    oe_n = 1'b1;
  end
endmodule

// File: tb/tb_top.sv
/*
  Self-checking bench for the burst memory core with a bus model.
  Assumes a 100 MHz clock and a six-bit word address.
*/
`timescale 1ns/100ps
module tb_top;
  import sram_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sleep = 1'b0;
  logic strap = 1'b0;
  bus_ctl_t ctl;
  logic [5:0] addr;
  logic [DATA_W-1:0] d_i, d_o, e;
  logic oe_n, d_oe_n;
  logic [DATA_W-1:0] mem [64];
  logic [DATA_W-1:0] exp_q [$];
  int n_errors = 0;
  int checked = 0;
  int seed = 10685;
  always #5 clk = ~clk;
  sram_burst_core #(.ADDR_W(6)) sram_burst_core_inst (.CLK_SYS(clk),
    .ARST_N(arst_n), .CTL(ctl), .ADDR(addr), .D_I(d_i),
    .OUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep), .BURST_ORDER_STRAP(strap),
    .D_O(d_o), .D_OE_N(d_oe_n));
  bus_model bus_model_inst (.clk(clk), .ctl(ctl), .addr(addr), .d_i(d_i),
    .oe_n(oe_n));
  // ==========================================================
  // Model and drivers
  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'({$random(seed), $random(seed)});
  endfunction
  function automatic logic [1:0] nxt(input logic [1:0] s, b);
    return strap ? (s ^ b) : (s + b);
  endfunction
  task automatic cw(input logic [5:0] a, input logic [DATA_W-1:0] d,
                    input logic gw, be, input logic [3:0] bw);
    // No lane selected: the strobe starts a read, shown once OE drops
    if (gw && (be || bw == 4'hF)) begin
      exp_q.push_back(mem[a]);
    end
    for (int i = 0; i < LANES; i++) begin
      if (!gw || (!be && !bw[i])) begin
        mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      end
    end
    bus_model_inst.cwrite(a, d, gw, be, bw);
  endtask
  task automatic rd(input logic [5:0] a, input int n);
    for (int b = 0; b < n; b++) begin
      exp_q.push_back(mem[{a[5:2], nxt(a[1:0], 2'(b))}]);
    end
    bus_model_inst.read(a, n);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Output watcher: every driven cycle must match the oldest note
  always @(negedge clk) begin
    if (arst_n && d_oe_n === 1'b0) begin
      checked++;
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("MISMATCH d_o expected tri-state seen %h", d_o);
      end else begin
        e = exp_q.pop_front();
        if (d_o !== e) begin
          n_errors++;
          $display("MISMATCH d_o expected %h seen %h", e, d_o);
        end
      end
    end
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog expected end seen timeout");
    complete_run();
  end
  // ==========================================================
  // Main sequence, once per burst order
  logic [5:0] a;
  initial begin
    for (int o = 0; o < 2; o++) begin
      arst_n = 1'b0;
      strap = o[0];
      repeat (16) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      for (int i = 0; i < 64; i++) begin
        cw(6'(i), rnd(), 1'b0, 1'($random(seed)), 4'($random(seed)));
      end
      for (int s = 0; s < 4; s++) begin
        rd({4'($random(seed)), 2'(s)}, 4);
      end
      for (int i = 0; i < 6; i++) begin
        a = 6'($random(seed));
        cw(a, rnd(), 1'b1, i[0], 4'($random(seed)));
        rd(a, 1);
        a = 6'($random(seed));
        bus_model_inst.pwrite(a, e);
        mem[a] = e;
        rd(a, 4);
        cw(a, rnd(), 1'b0, 1'b1, 4'hF);
        rd(a, 2);
      end
      bus_model_inst.idle(2);
      sleep = 1'b1;
      bus_model_inst.idle(4);
      sleep = 1'b0;
      bus_model_inst.idle(3);
      rd(6'($random(seed)), 4);
    end
    bus_model_inst.idle(3);
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("MISMATCH reads expected 0 left seen %0d", exp_q.size());
    end
    complete_run();
  end
endmodule
